// [hdl/frr_consts.svh]
// Constants for the fault record readout block.
`ifndef FRR_CONSTS_SVH
`define FRR_CONSTS_SVH
`define FRR_CMD_CODE 8'hde
`define FRR_RD_PARAM_LEN 8'h01
`define FRR_ERASE_LEN 8'h02
`define FRR_ERASE_KEY0 8'hfe
`define FRR_ERASE_KEY1 8'h00
`define FRR_REC_BYTES 8'h40
`define FRR_CRC_POLY 8'h07
`define FRR_CRC_INIT 8'h00
`define FRR_BYTE_ID 0
`define FRR_BYTE_FLAGS 2
`define FRR_BYTE_ACTION 3
`define FRR_BYTE_RULE 4
`define FRR_BYTE_HIGH 5
`define FRR_BYTE_CUR 6
`define FRR_BYTE_LAST 8
`define FRR_BYTE_LOW_OV 10
`define FRR_BYTE_LOW_UV 12
`define FRR_BYTE_GP_IN 14
`define FRR_BYTE_GP_OUT 16
`define FRR_BYTE_DRV_IN 18
`define FRR_BYTE_DRV_OUT 20
`define FRR_BYTE_PCOUNT 22
`define FRR_BYTE_TIME 24
`define FRR_BYTE_CRC 63
`define FRR_FLAG_EMPTY 0
`define FRR_FLAG_PAGE 4
`define FRR_FLAG_JUMP 7
`define FRR_PAGE_SHIFT 2
`endif

// [hdl/frr_pkg.sv]
// Types for the fault record readout block.
package frr_pkg;
   typedef struct packed {
      logic [7:0] action;
      logic [7:0] rule;
      logic jump_by_message;
      logic [3:0] high_rail_over_bits;
      logic [3:0] high_rail_under_bits;
      logic [15:0] cur_state;
      logic [15:0] last_state;
      logic [12:0] low_rail_over_bits;
      logic [12:0] low_rail_under_bits;
      logic [8:0] gp_pin_in;
      logic [8:0] gp_pin_out;
      logic [15:0] driver_pin_input_snapshot;
      logic [15:0] driver_pin_output_snapshot;
      logic [15:0] power_cycle_count;
      logic [63:0] record_time;
   } frr_snap_t;
   typedef enum logic [2:0] {
      FRR_IDLE, FRR_LEN, FRR_P1, FRR_P2, FRR_WAIT, FRR_READ, FRR_SKIP
   } frr_state_t;
endpackage : frr_pkg

// [hdl/frr_top.sv]
// Fault record store with its block write-read and erase command handler.
// Overview of operation
// - Read request is a write of length byte 1 then one record index byte.
// - Read part returns a length byte then the 64 bytes of that record.
// - Bytes 0-1 hold a record ID numbered identically on all cascaded devices.
// - Byte 2 empty flag is 0 for a stored record, 1 for an empty slot.
// - Byte 2 also holds the page index and the jump cause bit.
// - Byte 3 holds the action index and byte 4 the rule index.
// - Byte 5 bits 0-3 high rail overvoltage, bits 4-7 undervoltage.
// - Bytes 6-7 hold the current state, bytes 8-9 the previous state.
// - Bytes 10-13 hold low rail over and under bits, bits 13-15 reserved.
// - Bytes 14-17 hold general pin levels with the documented bit mapping.
// - Bytes 18-21 hold driver pin input and output levels, bit n is pin n+1.
// - Bytes 22-23 hold the power cycle count at recording time.
// - Bytes 24-31 hold the timestamp captured at the trigger.
// - Bytes 32-62 are reserved and byte 63 holds the record checksum.
`include "frr_consts.svh"
module frr_top #(
   parameter int NREC = 32
) (
   // Clock, reset and enable
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   input wire logic CE_IN,
   // Byte stream from the host interface (command code first)
   input wire logic START_IN,
   input wire logic WR_VALID_IN,
   input wire logic [7:0] WR_BYTE_IN,
   input wire logic STOP_IN,
   input wire logic RD_REQ_IN,
   // Read answer
   output logic RD_VALID_OUT,
   output logic [7:0] RD_BYTE_OUT,
   output logic CRC_ERR_OUT,
   output logic ERASE_DONE_OUT,
   // Record trigger from the sequencing engine
   input wire logic TRIG_IN,
   input wire frr_pkg::frr_snap_t SNAP_IN,
   output logic REC_DONE_OUT
);
   import frr_pkg::*;

   localparam int IW = $clog2(NREC);

   // ------------------------------------------------------------
   // Record layout and checksum
   // ------------------------------------------------------------
   function automatic logic [7:0] crc8(input logic [503:0] body);
      logic [7:0] c;
      c = `FRR_CRC_INIT;
      for (int i = 0; i < 504; i++) begin
         c = (c[7] ^ body[i]) ? ({c[6:0], 1'b0} ^ `FRR_CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8

   function automatic logic [511:0] seal(input logic [503:0] body);
      return {crc8(body), body};
   endfunction : seal

   function automatic logic [15:0] gp_map(input logic [8:0] p);
      // Pins 1-3 in bits 0-2, pins 8-9 in bits 6-7, pins 4-7 in bits 8-11.
      return {4'h0, p[6:3], p[8:7], 3'h0, p[2:0]};
   endfunction : gp_map

   function automatic logic [503:0] build(input frr_snap_t s, input logic [15:0] id,
                                          input logic [2:0] page);
      logic [503:0] b;
      b = '0;
      b[`FRR_BYTE_ID*8 +: 16] = id;
      b[`FRR_BYTE_FLAGS*8 + `FRR_FLAG_EMPTY] = 1'b0;
      b[`FRR_BYTE_FLAGS*8 + `FRR_FLAG_PAGE +: 3] = page;
      b[`FRR_BYTE_FLAGS*8 + `FRR_FLAG_JUMP] = s.jump_by_message;
      b[`FRR_BYTE_ACTION*8 +: 8] = s.action;
      b[`FRR_BYTE_RULE*8 +: 8] = s.rule;
      b[`FRR_BYTE_HIGH*8 +: 8] = {s.high_rail_under_bits, s.high_rail_over_bits};
      b[`FRR_BYTE_CUR*8 +: 16] = s.cur_state;
      b[`FRR_BYTE_LAST*8 +: 16] = s.last_state;
      b[`FRR_BYTE_LOW_OV*8 +: 16] = {3'h0, s.low_rail_over_bits};
      b[`FRR_BYTE_LOW_UV*8 +: 16] = {3'h0, s.low_rail_under_bits};
      b[`FRR_BYTE_GP_IN*8 +: 16] = gp_map(s.gp_pin_in);
      b[`FRR_BYTE_GP_OUT*8 +: 16] = gp_map(s.gp_pin_out);
      b[`FRR_BYTE_DRV_IN*8 +: 16] = s.driver_pin_input_snapshot;
      b[`FRR_BYTE_DRV_OUT*8 +: 16] = s.driver_pin_output_snapshot;
      b[`FRR_BYTE_PCOUNT*8 +: 16] = s.power_cycle_count;
      b[`FRR_BYTE_TIME*8 +: 64] = s.record_time;
      return b;
   endfunction : build

   // ------------------------------------------------------------
   // Record store
   // ------------------------------------------------------------
   logic [511:0] mem [NREC];
   logic [NREC-1:0] used;
   logic [IW-1:0] wr_ptr;
   logic [15:0] next_id;
   logic erase_req;

   // Erase has priority over a trigger in the same cycle, so the slot
   // being erased can never come back as a half-valid record.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         used <= '0;
         wr_ptr <= '0;
         next_id <= 16'h0000;
         REC_DONE_OUT <= 1'b0;
         ERASE_DONE_OUT <= 1'b0;
      end else if (CE_IN) begin
         REC_DONE_OUT <= 1'b0;
         ERASE_DONE_OUT <= 1'b0;
         if (erase_req) begin
            used <= '0;
            wr_ptr <= '0;
            next_id <= 16'h0000;
            ERASE_DONE_OUT <= 1'b1;
         end else if (TRIG_IN) begin
            used[wr_ptr] <= 1'b1;
            wr_ptr <= (wr_ptr == IW'(NREC - 1)) ? '0 : wr_ptr + 1'b1;
            next_id <= next_id + 16'h0001;
            REC_DONE_OUT <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (CE_IN && !erase_req && TRIG_IN) begin
         mem[wr_ptr] <= seal(build(SNAP_IN, next_id,
                                   3'(wr_ptr >> `FRR_PAGE_SHIFT)));
      end
   end

   // ------------------------------------------------------------
   // Command handler
   // ------------------------------------------------------------
   frr_state_t state;
   logic [7:0] len;
   logic [7:0] p1;
   logic [7:0] p2;
   logic [7:0] rd_cnt;
   logic [511:0] rd_rec;
   logic [511:0] empty_rec;

   always_comb begin
      empty_rec = '0;
      empty_rec[`FRR_BYTE_FLAGS*8 + `FRR_FLAG_EMPTY] = 1'b1;
      empty_rec = seal(empty_rec[503:0]);
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         state <= FRR_IDLE;
         len <= 8'h00;
         p1 <= 8'h00;
         p2 <= 8'h00;
         rd_cnt <= 8'h00;
         rd_rec <= '0;
         erase_req <= 1'b0;
         RD_VALID_OUT <= 1'b0;
         RD_BYTE_OUT <= 8'h00;
         CRC_ERR_OUT <= 1'b0;
      end else if (CE_IN) begin
         erase_req <= 1'b0;
         RD_VALID_OUT <= 1'b0;
         if (START_IN) begin
            state <= FRR_IDLE;
         end else begin
            case (state)
               FRR_IDLE: begin
                  if (WR_VALID_IN) begin
                     state <= (WR_BYTE_IN == `FRR_CMD_CODE) ? FRR_LEN : FRR_SKIP;
                  end
               end
               FRR_LEN: begin
                  if (WR_VALID_IN) begin
                     len <= WR_BYTE_IN;
                     state <= FRR_P1;
                  end
               end
               FRR_P1: begin
                  if (WR_VALID_IN) begin
                     p1 <= WR_BYTE_IN;
                     if (len == `FRR_RD_PARAM_LEN) begin
                        // Index past the store reads as an empty slot.
                        if (WR_BYTE_IN < 8'(NREC) && used[IW'(WR_BYTE_IN)]) begin
                           rd_rec <= mem[IW'(WR_BYTE_IN)];
                           CRC_ERR_OUT <= crc8(mem[IW'(WR_BYTE_IN)][503:0]) !=
                              mem[IW'(WR_BYTE_IN)][`FRR_BYTE_CRC*8 +: 8];
                        end else begin
                           rd_rec <= empty_rec;
                           CRC_ERR_OUT <= 1'b0;
                        end
                        rd_cnt <= 8'h00;
                        state <= FRR_READ;
                     end else if (len == `FRR_ERASE_LEN) begin
                        state <= FRR_P2;
                     end else begin
                        state <= FRR_SKIP;
                     end
                  end
               end
               FRR_P2: begin
                  if (WR_VALID_IN) begin
                     p2 <= WR_BYTE_IN;
                     state <= FRR_WAIT;
                  end
               end
               FRR_WAIT: begin
                  // The erase only acts at the stop, so an overlong write is refused.
                  if (WR_VALID_IN) begin
                     state <= FRR_SKIP;
                  end else if (STOP_IN) begin
                     erase_req <= (p1 == `FRR_ERASE_KEY0) && (p2 == `FRR_ERASE_KEY1);
                     state <= FRR_IDLE;
                  end
               end
               FRR_READ: begin
                  if (RD_REQ_IN) begin
                     RD_VALID_OUT <= 1'b1;
                     if (rd_cnt == 8'h00) begin
                        RD_BYTE_OUT <= `FRR_REC_BYTES;
                     end else if (rd_cnt <= `FRR_REC_BYTES) begin
                        RD_BYTE_OUT <= rd_rec[(rd_cnt - 8'h01)*8 +: 8];
                     end else begin
                        RD_BYTE_OUT <= 8'hff;
                     end
                     if (rd_cnt <= `FRR_REC_BYTES) begin
                        rd_cnt <= rd_cnt + 8'h01;
                     end
                  end
                  if (STOP_IN) begin
                     state <= FRR_IDLE;
                  end
               end
               FRR_SKIP: begin
                  if (STOP_IN) begin
                     state <= FRR_IDLE;
                  end
               end
               default: begin
                  state <= FRR_IDLE;
               end
            endcase
         end
      end
   end
endmodule : frr_top

// [bench/frr_host.sv]
// Host-side model issuing block read and erase commands as a byte stream.
module frr_host (
   // Clock
   input wire logic clk_in,
   // Byte stream towards the block
   output logic start_out,
   output logic wr_valid_out,
   output logic [7:0] wr_byte_out,
   output logic stop_out,
   output logic rd_req_out,
   // Answers from the block
   input wire logic rd_valid_in,
   input wire logic [7:0] rd_byte_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   initial begin
      {start_out, wr_valid_out, stop_out, rd_req_out} = 4'h0;
      wr_byte_out = 8'h00;
   end
   always @(posedge clk_in) begin
      if (rd_valid_in === 1'b1) begin
         got.push_back(rd_byte_in);
      end
   end
   task automatic mark(input logic is_stop);
      @(posedge clk_in);
      start_out <= !is_stop;
      stop_out <= is_stop;
      @(posedge clk_in);
      start_out <= 1'b0;
      stop_out <= 1'b0;
   endtask : mark
   // The byte lines flip on release so a stale value is never mistaken for data.
   task automatic send(input logic [7:0] b);
      @(posedge clk_in);
      wr_valid_out <= 1'b1;
      wr_byte_out <= b;
      @(posedge clk_in);
      wr_valid_out <= 1'b0;
      wr_byte_out <= ~b;
   endtask : send
   task automatic fetch(input logic [7:0] idx, input int n);
      got.delete();
      mark(1'b0);
      send(8'hde);
      send(8'h01);
      send(idx);
      @(posedge clk_in);
      rd_req_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      rd_req_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      mark(1'b1);
   endtask : fetch
   task automatic erase(input logic [7:0] key);
      mark(1'b0);
      send(8'hde);
      send(8'h02);
      send(8'hfe);
      send(key);
      mark(1'b1);
   endtask : erase
endmodule : frr_host

// [bench/frr_assertions.sv]
// Concurrent checks on the ports of the fault record block.
module frr_checker #(
   parameter int NREC = 32
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   // Host side
   input wire logic START_IN,
   input wire logic WR_VALID_IN,
   input wire logic [7:0] WR_BYTE_IN,
   input wire logic STOP_IN,
   input wire logic RD_REQ_IN,
   input wire logic RD_VALID_OUT,
   input wire logic [7:0] RD_BYTE_OUT,
   input wire logic CRC_ERR_OUT,
   input wire logic ERASE_DONE_OUT,
   // Record side
   input wire logic TRIG_IN,
   input wire logic REC_DONE_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] n_ans;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   // Answers since the last start; zero is the length byte, so byte n is n_ans n+1.
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN || START_IN) begin
         n_ans <= 8'h00;
      end else if (RD_VALID_OUT && n_ans != 8'hff) begin
         n_ans <= n_ans + 8'h01;
      end
   end
   sequence s_b(logic [7:0] v);
      WR_VALID_IN && WR_BYTE_IN == v;
   endsequence
   sequence s_rd_cmd;
      s_b(8'hde) ##2 s_b(8'h01) ##2 WR_VALID_IN ##2 RD_REQ_IN;
   endsequence
   sequence s_erase_cmd;
      s_b(8'hde) ##2 s_b(8'h02) ##2 s_b(8'hfe) ##2 s_b(8'h00) ##2 STOP_IN;
   endsequence
   property p_len; s_rd_cmd |=> RD_VALID_OUT && RD_BYTE_OUT == 8'h40; endproperty
   a_len: assert property (p_len) else $error("length byte wrong");
   property p_ans; RD_VALID_OUT |-> $past(RD_REQ_IN); endproperty
   a_ans: assert property (p_ans) else $error("answer without request");
   property p_over; RD_VALID_OUT && n_ans > 8'h40 |-> RD_BYTE_OUT == 8'hff; endproperty
   a_over: assert property (p_over) else $error("overrun byte wrong");
   property p_flag; RD_VALID_OUT && n_ans == 8'h03 |-> RD_BYTE_OUT[3:1] == 3'h0; endproperty
   a_flag: assert property (p_flag) else $error("flag byte reserved bits set");
   property p_tail;
      RD_VALID_OUT && n_ans > 8'h20 && n_ans < 8'h40 |-> RD_BYTE_OUT == 8'h00;
   endproperty
   a_tail: assert property (p_tail) else $error("reserved byte not zero");
   property p_low; RD_VALID_OUT && n_ans == 8'h0c |-> RD_BYTE_OUT[7:5] == 3'h0; endproperty
   a_low: assert property (p_low) else $error("low rail reserved bits set");
   property p_erase; s_erase_cmd |-> ##2 ERASE_DONE_OUT; endproperty
   a_erase: assert property (p_erase) else $error("erase not done");
   property p_erase_src; ERASE_DONE_OUT |-> $past(STOP_IN, 2) ##1 !ERASE_DONE_OUT; endproperty
   a_erase_src: assert property (p_erase_src) else $error("stray erase pulse");
   property p_rec; REC_DONE_OUT |-> $past(TRIG_IN); endproperty
   a_rec: assert property (p_rec) else $error("record without trigger");
   property p_crc; !CRC_ERR_OUT; endproperty
   a_crc: assert property (p_crc) else $error("checksum mismatch");
endmodule : frr_checker
bind frr_top frr_checker #(.NREC(NREC)) u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
   .START_IN(START_IN), .WR_VALID_IN(WR_VALID_IN), .WR_BYTE_IN(WR_BYTE_IN),
   .STOP_IN(STOP_IN), .RD_REQ_IN(RD_REQ_IN), .RD_VALID_OUT(RD_VALID_OUT),
   .RD_BYTE_OUT(RD_BYTE_OUT), .CRC_ERR_OUT(CRC_ERR_OUT), .ERASE_DONE_OUT(ERASE_DONE_OUT),
   .TRIG_IN(TRIG_IN), .REC_DONE_OUT(REC_DONE_OUT));

// [bench/tb_top.sv]
// Self-checking bench for the fault record block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import frr_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic trig = 1'b0;
   logic ce = 1'b1;
   frr_snap_t snap = '0;
   logic start, wv, stop, rq, rv, crc_err, edone, rdone;
   logic [7:0] wb, rb;
   int num_errors = 0;
   int n_checks = 0;
   int n_erase = 0;
   int n_rec = 0;
   int cyc = 0;
   frr_snap_t snaps [6];
   always #5 clk = ~clk;
   frr_host u_host (.clk_in(clk), .start_out(start), .wr_valid_out(wv), .wr_byte_out(wb),
      .stop_out(stop), .rd_req_out(rq), .rd_valid_in(rv), .rd_byte_in(rb));
   // Eight slots keep the page field reachable with only a handful of records.
   frr_top #(.NREC(8)) u_dut (.CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .START_IN(start),
      .WR_VALID_IN(wv), .WR_BYTE_IN(wb), .STOP_IN(stop), .RD_REQ_IN(rq), .RD_VALID_OUT(rv),
      .RD_BYTE_OUT(rb), .CRC_ERR_OUT(crc_err), .ERASE_DONE_OUT(edone), .TRIG_IN(trig),
      .SNAP_IN(snap), .REC_DONE_OUT(rdone));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_erase <= n_erase + int'(edone === 1'b1);
      n_rec <= n_rec + int'(rdone === 1'b1);
      if (cyc == 2500) begin
         num_errors++;
         results();
      end
   end
   function automatic logic [15:0] gp16(input logic [8:0] p);
      return {4'h0, p[6:3], p[8:7], 3'h0, p[2:0]};
   endfunction : gp16
   function automatic logic [511:0] mk(input int k, input logic empty);
      logic [511:0] r;
      logic [7:0] c;
      frr_snap_t s;
      s = snaps[k];
      r = 512'h1 << 16;
      if (!empty) begin
         r[255:0] = {s.record_time, s.power_cycle_count, s.driver_pin_output_snapshot,
            s.driver_pin_input_snapshot, gp16(s.gp_pin_out), gp16(s.gp_pin_in),
            3'h0, s.low_rail_under_bits, 3'h0, s.low_rail_over_bits, s.last_state,
            s.cur_state, s.high_rail_under_bits, s.high_rail_over_bits, s.rule, s.action,
            s.jump_by_message, 3'(k >> 2), 4'h0, 16'(k)};
      end
      c = 8'h00;
      for (int i = 0; i < 504; i++) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ r[i]) ? 8'h07 : 8'h00);
      end
      r[511:504] = c;
      return r;
   endfunction : mk
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic check_rec(input logic [7:0] idx, input logic [511:0] e);
      u_host.fetch(idx, 66);
      chk(8'(u_host.got.size()), 8'h42);
      chk(u_host.got[0], 8'h40);
      for (int i = 0; i < 64; i++) begin
         chk(u_host.got[i + 1], e[8 * i +: 8]);
      end
      chk(u_host.got[65], 8'hff);
      chk(8'(crc_err), 8'h00);
   endtask : check_rec
   task automatic t_store();
      logic [223:0] v;
      for (int k = 0; k < 6; k++) begin
         v = {7{32'h5a3c96e1 ^ (32'(k) * 32'h01030507)}};
         snaps[k] = v[$bits(frr_snap_t) - 1:0];
         @(posedge clk);
         trig <= 1'b1;
         snap <= snaps[k];
         @(posedge clk);
         trig <= 1'b0;
         snap <= ~snaps[k];
      end
      // A trigger while the clock enable is low must leave the store untouched.
      @(posedge clk);
      ce <= 1'b0;
      trig <= 1'b1;
      @(posedge clk);
      ce <= 1'b1;
      trig <= 1'b0;
      check_rec(8'h00, mk(0, 1'b0));
      check_rec(8'h03, mk(3, 1'b0));
      check_rec(8'h05, mk(5, 1'b0));
      check_rec(8'h06, mk(0, 1'b1));
      chk(8'(n_rec), 8'h06);
      $display("store test done");
   endtask : t_store
   task automatic t_erase(input logic [7:0] key, input int n_exp, input logic gone);
      u_host.erase(key);
      repeat (4) @(posedge clk);
      chk(8'(n_erase), 8'(n_exp));
      check_rec(8'h05, mk(5, gone));
      $display("erase test done");
   endtask : t_erase
   // After an erase the first record restarts at slot 0 with ID 0; a reset empties it again.
   task automatic t_reset();
      @(posedge clk);
      trig <= 1'b1;
      snap <= snaps[0];
      @(posedge clk);
      trig <= 1'b0;
      check_rec(8'h00, mk(0, 1'b0));
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      check_rec(8'h00, mk(0, 1'b1));
      $display("reset test done");
   endtask : t_reset
   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      check_rec(8'h09, mk(0, 1'b1));
      $display("empty test done");
      t_store();
      t_erase(8'h01, 0, 1'b0);
      t_erase(8'h00, 1, 1'b1);
      t_reset();
      results();
   end
endmodule : tb_top
